// File: common/sdm_init_mode_regs.vh
// Field positions, command codes and timing counts of the DRAM command and mode logic.
`ifndef SDM_INIT_MODE_REGS_VH
`define SDM_INIT_MODE_REGS_VH

// ==========================================================================
// Bank-address codes that pick a mode register.
`define SDM_BA_MR0 3'h0
`define SDM_BA_MR1 3'h1
`define SDM_BA_MR2 3'h2
`define SDM_BA_MR3 3'h3

// ==========================================================================
// Command codes as {ras_n, cas_n, we_n} with chip select low.
`define SDM_CMD_MODE 3'h0
`define SDM_CMD_ACT 3'h3
`define SDM_CMD_PRE 3'h2
`define SDM_CMD_RD 3'h5
`define SDM_CMD_WR 3'h4
`define SDM_CMD_CAL 3'h6

// ==========================================================================
// Address bits of column commands and mode register zero fields.
`define SDM_AUTO_PRE_BIT 10
`define SDM_CHOP_BIT 12
`define SDM_MR0_BL_MSB 1
`define SDM_MR0_BL_LSB 0
`define SDM_MR0_BT_BIT 3
`define SDM_MR0_CL_LO_BIT 2
`define SDM_MR0_CL_MSB 6
`define SDM_MR0_CL_LSB 4
`define SDM_MR0_DLL_RST_BIT 8
`define SDM_MR0_WR_MSB 11
`define SDM_MR0_WR_LSB 9
`define SDM_MR0_PPD_BIT 12
`define SDM_BL_FIXED8 2'h0
`define SDM_BL_OTF 2'h1
`define SDM_BL_FIXED4 2'h2

// ==========================================================================
// Mode register one and two fields.
`define SDM_MR1_DLL_OFF_BIT 0
`define SDM_MR1_AL_MSB 4
`define SDM_MR1_AL_LSB 3
`define SDM_MR1_RTT_B0 2
`define SDM_MR1_RTT_B1 6
`define SDM_MR1_RTT_B2 9
`define SDM_MR2_CWL_MSB 5
`define SDM_MR2_CWL_LSB 3

// ==========================================================================
// Latency bases and timing in link clocks; reset value of mode registers.
`define SDM_CL_BASE 5'h04
`define SDM_CWL_BASE 5'h05
`define SDM_DLL_LOCK_TCK 10'h200
`define SDM_CAL_INIT_TCK 10'h200
`define SDM_PRECHARGE_TCK 5'h0b
`define SDM_MR_RESET 13'h0000

// ==========================================================================
// Internal state initialisation after reset release.
`define SDM_INIT_WAIT_US 500
`define SDM_CLK_MHZ 250

`endif

// File: hdl/sdm_init_mode_dev.v
// Device-side command decoder, initialisation sequencer and mode registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_init_mode_regs.vh"

// Behaviour
// [R1] Activate takes bank and row; eight banks
// [R2] One 8n word as eight half-clock beats
// [R3] Column command: column, auto-precharge, chop select
// [R4] Controller activates a row before access; the bench sends one read to closed bank 0, which the device drops
// [R5] Controller holds reset, lowers enable first
// [R6] Internal initialisation runs after reset release
// [R7] Controller runs clock before raising enable
// [R8] Controller keeps enable high through initialisation
// [R9] Termination off until enable registered high
// [R10] Controller keeps termination control static
// [R11] Controller waits reset exit before mode write
// [R12] Controller writes modes in order, then calibrates
// [R13] Controller waits lock and calibration times
// [R14] Warm reset repeats the sequence
// [R15] Controller writes every register completely
// [R16] Mode writes leave array contents unchanged
// [R17] Controller spaces mode writes by cycle time
// [R18] Controller waits update delay after mode write
// [R19] Mode writes only while device idle
// [R20] All-low command with bank zero writes register zero
// [R21] Controller writes reserved bits as zero
// [R22] Write recovery plus precharge forms write delay
// [R23] First read data after additive plus column latency
// [R24] DLL reset bit clears itself after use
// [R25] Register zero selects burst length and order; order bit only held, bursts stay sequential
module sdm_init_mode_dev
#(
	parameter DQ_W = 8,
	parameter INIT_WAIT_CYC = `SDM_INIT_WAIT_US * `SDM_CLK_MHZ
)
(
	// System clock and reset.
	input wire clk_sys,
	input wire rst_n,
	// Link pins from the memory controller.
	input wire link_ck,
	input wire mem_reset_n,
	input wire cke,
	input wire cs_n,
	input wire ras_n,
	input wire cas_n,
	input wire we_n,
	input wire [2:0] bank_select,
	input wire [12:0] addr,
	input wire termination_control,
	// Data pins, split into input, output and enable.
	input wire [DQ_W-1:0] dq_in,
	output reg [DQ_W-1:0] dq_out,
	output reg dq_oe,
	// Status.
	output wire termination_on,
	output reg internal_init_busy,
	output reg init_done,
	output reg [7:0] bank_open,
	output wire [4:0] read_latency_total,
	output wire [4:0] auto_precharge_write_delay
);

	localparam ST_RESET = 3'h0;
	localparam ST_WAIT_CKE = 3'h1;
	localparam ST_CONFIG = 3'h2;
	localparam ST_CAL = 3'h3;
	localparam ST_READY = 3'h4;
	localparam X_IDLE = 2'h0;
	localparam X_LAT = 2'h1;
	localparam X_DATA = 2'h2;
	localparam SW = 32 + DQ_W;

	// ======================================================================
	// Pin synchronisation and link clock edge detection.
	wire [SW-1:0] pins_s;
	sdm_sync #(.WIDTH(SW)) u_sync
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({link_ck, mem_reset_n, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
			termination_control, dq_in, 8'h00}),
		.sync_out(pins_s)
	);
	wire ck_s = pins_s[SW-1];
	wire mrst_s = pins_s[SW-2];
	wire cke_s = pins_s[SW-3];
	wire cs_s = pins_s[SW-4];
	wire [2:0] cmd_s = pins_s[SW-5:SW-7];
	wire [2:0] ba_s = pins_s[SW-8:SW-10];
	wire [12:0] a_s = pins_s[SW-11:SW-23];
	wire odt_s = pins_s[SW-24];
	wire [DQ_W-1:0] dq_s = pins_s[DQ_W+7:8];
	reg ck_d;
	reg cke_q;
	wire rise = ck_s & ~ck_d;
	wire fall = ~ck_s & ck_d;
	wire edge_any = rise | fall;
	wire cmd_ok = rise & cke_q & cke_s & ~cs_s;

	// ======================================================================
	// State and storage.
	reg [2:0] state;
	reg [12:0] mode_reg_zero;
	reg [12:0] mode_reg_one;
	reg [12:0] mode_reg_two;
	reg [12:0] mode_reg_three;
	reg [12:0] open_row [0:7];
	reg [63:0] mem [0:127];
	reg [16:0] init_cnt;
	reg [9:0] dll_cnt;
	reg [9:0] cal_cnt;
	reg odt_armed;
	reg [1:0] xstate;
	reg xwrite;
	reg xchop;
	reg [6:0] xidx;
	reg xhalf;
	reg xap;
	reg [2:0] xbank;
	reg [4:0] lat_cnt;
	reg [2:0] beat;
	reg [63:0] shift;
	reg ap_pend;
	reg [2:0] ap_bank;
	reg [4:0] ap_cnt;
	integer i;

	// ======================================================================
	// Latency decode from the mode registers.
	wire [4:0] col_lat = {2'h0, mode_reg_zero[`SDM_MR0_CL_MSB:`SDM_MR0_CL_LSB]} + `SDM_CL_BASE; // [R23]
	wire [1:0] al_code = mode_reg_one[`SDM_MR1_AL_MSB:`SDM_MR1_AL_LSB];
	wire [4:0] add_lat = (al_code == 2'h1) ? col_lat - 5'h01 :
		(al_code == 2'h2) ? col_lat - 5'h02 : 5'h00;
	wire [4:0] cwl = {2'h0, mode_reg_two[`SDM_MR2_CWL_MSB:`SDM_MR2_CWL_LSB]} + `SDM_CWL_BASE;
	wire [4:0] wr_lat = add_lat + cwl;
	reg [4:0] wr_rec;
	assign read_latency_total = add_lat + col_lat; // [R23]
	assign auto_precharge_write_delay = wr_rec + `SDM_PRECHARGE_TCK; // [R22]

	// Write recovery code to link clocks; zero code means the longest value.
	always @*
	begin
		case (mode_reg_zero[`SDM_MR0_WR_MSB:`SDM_MR0_WR_LSB]) // [R22]
			3'h1: wr_rec = 5'h05;
			3'h2: wr_rec = 5'h06;
			3'h3: wr_rec = 5'h07;
			3'h4: wr_rec = 5'h08;
			3'h5: wr_rec = 5'h0a;
			3'h6: wr_rec = 5'h0c;
			3'h7: wr_rec = 5'h0e;
			default: wr_rec = 5'h10;
		endcase
	end

	// Burst length: fixed eight, fixed chop, or chosen by the chop bit.
	wire [1:0] bl_mode = mode_reg_zero[`SDM_MR0_BL_MSB:`SDM_MR0_BL_LSB]; // [R25]
	wire chop_now = (bl_mode == `SDM_BL_OTF) ? ~a_s[`SDM_CHOP_BIT] : (bl_mode == `SDM_BL_FIXED4); // [R3]
	// Burst order within the word is left sequential; the order bit is held only.
	wire rtt_nom_set = mode_reg_one[`SDM_MR1_RTT_B0] | mode_reg_one[`SDM_MR1_RTT_B1] |
		mode_reg_one[`SDM_MR1_RTT_B2];
	// Termination stays high impedance until enable has been registered high.
	assign termination_on = odt_armed & odt_s & rtt_nom_set; // [R9]
	wire is_cmd_mode = cmd_ok & (cmd_s == `SDM_CMD_MODE);
	wire [6:0] idx_now = {ba_s, open_row[ba_s][1:0], a_s[4:3]};

	// ======================================================================
	// Initialisation sequencer, mode registers and bank tracking.
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ck_d <= 1'b0;
			cke_q <= 1'b0;
			state <= ST_RESET;
			mode_reg_zero <= `SDM_MR_RESET;
			mode_reg_one <= `SDM_MR_RESET;
			mode_reg_two <= `SDM_MR_RESET;
			mode_reg_three <= `SDM_MR_RESET;
			init_cnt <= 17'h00000;
			dll_cnt <= 10'h000;
			cal_cnt <= 10'h000;
			odt_armed <= 1'b0;
			internal_init_busy <= 1'b0;
			init_done <= 1'b0;
			bank_open <= 8'h00;
			for (i = 0; i < 8; i = i + 1)
				open_row[i] <= 13'h0000;
		end
		else
		begin
			ck_d <= ck_s;
			if (rise)
				cke_q <= cke_s;
			if (!mrst_s)
			begin
				// Reset pin held: termination off, sequence restarts on release.
				state <= ST_RESET; // [R9] [R14]
				odt_armed <= 1'b0;
				init_done <= 1'b0;
				bank_open <= 8'h00;
				internal_init_busy <= 1'b1;
				init_cnt <= INIT_WAIT_CYC[16:0];
			end
			else
			begin
				// Internal initialisation counts without the link clock.
				if (init_cnt != 17'h00000)
					init_cnt <= init_cnt - 17'h00001; // [R6]
				else
					internal_init_busy <= 1'b0;
				case (state)
					ST_RESET: state <= ST_WAIT_CKE;
					ST_WAIT_CKE:
						if (rise && cke_s)
						begin
							state <= ST_CONFIG;
							odt_armed <= 1'b1; // [R9]
						end
					ST_CONFIG:
						if (cmd_ok && cmd_s == `SDM_CMD_CAL && a_s[`SDM_AUTO_PRE_BIT])
						begin
							state <= ST_CAL;
							cal_cnt <= `SDM_CAL_INIT_TCK;
						end
					ST_CAL:
						if (dll_cnt == 10'h000 && cal_cnt == 10'h000)
						begin
							state <= ST_READY;
							init_done <= 1'b1;
						end
					ST_READY: state <= ST_READY;
					default: state <= ST_RESET;
				endcase
				if (rise && cal_cnt != 10'h000)
					cal_cnt <= cal_cnt - 10'h001;
				// DLL reset bit falls back on the next link rise, which also starts its lock time.
				if (rise && dll_cnt != 10'h000)
					dll_cnt <= dll_cnt - 10'h001;
				if (rise && mode_reg_zero[`SDM_MR0_DLL_RST_BIT] && !is_cmd_mode)
				begin
					mode_reg_zero[`SDM_MR0_DLL_RST_BIT] <= 1'b0; // [R24]
					dll_cnt <= `SDM_DLL_LOCK_TCK;
				end
				// Mode writes touch only the registers, never the array.
				if (is_cmd_mode)
				begin
					case (ba_s) // [R16]
						`SDM_BA_MR0: mode_reg_zero <= a_s; // [R20]
						`SDM_BA_MR1: mode_reg_one <= a_s;
						`SDM_BA_MR2: mode_reg_two <= a_s;
						`SDM_BA_MR3: mode_reg_three <= a_s;
						default: mode_reg_three <= mode_reg_three;
					endcase
				end
				// An auto-precharge close comes before the activate, so a same-edge open wins.
				if (rise && ap_pend && ap_cnt == 5'h00)
					bank_open[ap_bank] <= 1'b0; // [R3]
				// Activate opens the addressed bank at the given row.
				if (cmd_ok && cmd_s == `SDM_CMD_ACT)
				begin
					bank_open[ba_s] <= 1'b1; // [R1]
					open_row[ba_s] <= a_s;
				end
				if (cmd_ok && cmd_s == `SDM_CMD_PRE)
				begin
					if (a_s[`SDM_AUTO_PRE_BIT])
						bank_open <= 8'h00;
					else
						bank_open[ba_s] <= 1'b0;
				end
			end
		end
	end

	// ======================================================================
	// Burst engine: one word, or half a word when chopped, per access, two beats per link clock.
	// Only one burst is in flight; a column command during a burst is dropped.
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xstate <= X_IDLE;
			xwrite <= 1'b0;
			xchop <= 1'b0;
			xidx <= 7'h00;
			xhalf <= 1'b0;
			xap <= 1'b0;
			xbank <= 3'h0;
			lat_cnt <= 5'h00;
			beat <= 3'h0;
			shift <= 64'h0;
			dq_out <= {DQ_W{1'b0}};
			dq_oe <= 1'b0;
			ap_pend <= 1'b0;
			ap_bank <= 3'h0;
			ap_cnt <= 5'h00;
		end
		else if (!mrst_s)
		begin
			xstate <= X_IDLE;
			dq_oe <= 1'b0;
			ap_pend <= 1'b0;
		end
		else
		begin
			if (rise && ap_pend)
			begin
				if (ap_cnt == 5'h00)
					ap_pend <= 1'b0;
				else
					ap_cnt <= ap_cnt - 5'h01;
			end
			case (xstate)
				X_IDLE:
					if (cmd_ok && (cmd_s == `SDM_CMD_RD || cmd_s == `SDM_CMD_WR) && bank_open[ba_s])
					begin
						xstate <= X_LAT;
						xwrite <= (cmd_s == `SDM_CMD_WR);
						xchop <= chop_now; // [R3]
						xidx <= idx_now;
						xhalf <= a_s[2];
						xap <= a_s[`SDM_AUTO_PRE_BIT]; // [R3]
						xbank <= ba_s;
						lat_cnt <= (cmd_s == `SDM_CMD_WR) ? wr_lat - 5'h01 :
							read_latency_total - 5'h01; // [R23]
					end
				X_LAT:
					if (rise)
					begin
						if (lat_cnt == 5'h00)
						begin
							xstate <= X_DATA;
							beat <= 3'h1;
							if (xwrite)
								shift <= {dq_s, shift[63:DQ_W]};
							else
							begin
								dq_oe <= 1'b1;
								dq_out <= (xchop && xhalf) ? mem[xidx][39:32] : mem[xidx][7:0];
								shift <= (xchop && xhalf) ? {mem[xidx][31:0], 8'h00, mem[xidx][63:40]} :
									{8'h00, mem[xidx][63:8]};
							end
						end
						else
							lat_cnt <= lat_cnt - 5'h01;
					end
				X_DATA:
					if (edge_any)
					begin
						// Each half clock moves one beat of the word.
						beat <= beat + 3'h1; // [R2]
						if (beat == (xchop ? 3'h4 : 3'h0))
						begin
							xstate <= X_IDLE;
							dq_oe <= 1'b0;
							if (xwrite)
							begin
								if (!xchop)
									mem[xidx] <= shift;
								else if (xhalf)
									mem[xidx] <= {shift[63:32], mem[xidx][31:0]};
								else
									mem[xidx] <= {mem[xidx][63:32], shift[63:32]};
							end
							if (xap)
							begin
								ap_pend <= 1'b1;
								ap_bank <= xbank;
								ap_cnt <= xwrite ? auto_precharge_write_delay : `SDM_PRECHARGE_TCK; // [R22]
							end
						end
						else if (xwrite)
							shift <= {dq_s, shift[63:DQ_W]};
						else
						begin
							dq_out <= shift[7:0];
							shift <= {8'h00, shift[63:DQ_W]};
						end
					end
				default: xstate <= X_IDLE;
			endcase
		end
	end

endmodule // sdm_init_mode_dev

`default_nettype wire

// File: hdl/sdm_sync.v
// Two flip-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/1ps
`default_nettype none

module sdm_sync
#(
	parameter WIDTH = 32
)
(
	// Clock and reset.
	input wire clk_sys,
	input wire rst_n,
	// Asynchronous inputs and their synchronised copies.
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta;

	// The first stage feeds only the second one, never any logic.
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule // sdm_sync

`default_nettype wire

// File: test/sdm_chk.sv
// Port checker for the DRAM command and mode block.
`timescale 1ns/1ps
`default_nettype none
module sdm_chk
#(
	parameter INIT_WAIT_CYC = 20
)
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Watched pins and status.
	input wire logic mem_reset_n,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	input wire logic termination_on,
	input wire logic internal_init_busy,
	input wire logic init_done,
	input wire logic [7:0] bank_open,
	input wire logic [4:0] auto_precharge_write_delay
);
	// =====
	// Helpers
	logic [15:0] oe_cnt;
	logic [15:0] up_cnt;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Drive length, and time since the reset pin rose, which saturates.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oe_cnt <= 16'h0000;
			up_cnt <= 16'h0000;
		end
		else
		begin
			oe_cnt <= dq_oe ? oe_cnt + 16'h0001 : 16'h0000;
			up_cnt <= mem_reset_n ? up_cnt + {15'h0000, ~&up_cnt} : 16'h0000;
		end
	end
	// Pins pass a synchroniser, so a reset counts once it has lasted four cycles.
	chk_term_reset: assert property (!mem_reset_n [*4] |-> !termination_on)
		else $error("termination in reset");
	chk_oe_reset: assert property (!mem_reset_n [*4] |-> !dq_oe)
		else $error("drive in reset");
	chk_bank_reset: assert property (!mem_reset_n [*4] |-> bank_open == 8'h00)
		else $error("bank open in reset");
	chk_done_reset: assert property (!mem_reset_n [*4] |-> !init_done)
		else $error("done in reset");
	chk_oe_len: assert property ($fell(dq_oe) |-> oe_cnt inside {[76:84], [156:164]})
		else $error("burst length");
	chk_beat_hold: assert property (dq_oe && $changed(dq_out) |=> $stable(dq_out) [*8])
		else $error("beat too short");
	chk_busy_len: assert property ($fell(internal_init_busy) |->
		up_cnt inside {[INIT_WAIT_CYC-1:INIT_WAIT_CYC+8]})
		else $error("init wait length");
	chk_done_busy: assert property (init_done |-> !internal_init_busy)
		else $error("done while busy");
	chk_dal_range: assert property (auto_precharge_write_delay inside {[16:27]})
		else $error("write delay range");
	cov_read: cover property ($rose(dq_oe));
	cov_done: cover property ($rose(init_done));
	cov_term: cover property ($rose(termination_on));
	cov_busy: cover property ($fell(internal_init_busy));
endmodule // sdm_chk
bind sdm_init_mode_dev sdm_chk #(.INIT_WAIT_CYC(INIT_WAIT_CYC)) sdm_chk_i (
	.clk_sys, .rst_n, .mem_reset_n, .dq_out, .dq_oe, .termination_on,
	.internal_init_busy, .init_done, .bank_open, .auto_precharge_write_delay
);
`default_nettype wire

// File: test/sdm_ctl.sv
// Behavioural memory controller driving the link pins.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_init_mode_regs.vh"
module sdm_ctl
#(
	parameter WAIT_CYC = 40
)
(
	// System clock.
	input wire logic clk_sys,
	// Link pins.
	output logic link_ck,
	output logic mem_reset_n,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] bank_select,
	output logic [12:0] addr,
	output logic termination_control,
	output logic [7:0] dq_in
);
	// =====
	// Link clock and pins
	logic [5:0] ph = 6'h00;
	// Link period is 40 system cycles; it runs free so it is stable long before enable.
	always @(posedge clk_sys)
		ph <= #1 (ph == 6'h27) ? 6'h00 : ph + 6'h01;
	assign link_ck = ph < 6'h14;
	// Reset asserted and enable low from time zero.
	initial
	begin
		mem_reset_n = 1'b0;
		cke = 1'b0;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		bank_select = 3'h0;
		addr = 13'h0000;
		termination_control = 1'b0;
		dq_in = 8'h00;
	end
	// Lines change in mid-phase, far from either link edge the block samples.
	task at(input logic [5:0] p);
		do @(posedge clk_sys); while (ph != p);
		#1;
	endtask
	task cmd(input logic [2:0] code, input logic [2:0] ba, input logic [12:0] a, input int gap);
		at(6'h1d);
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = code;
		bank_select = ba;
		addr = a;
		at(6'h1d);
		cs_n = 1'b1;
		bank_select = ~ba;
		addr = ~a;
		repeat (gap) at(6'h1d);
	endtask
	// Beat zero meets the fifth rising edge, then one byte per link edge.
	task wr(input logic [2:0] ba, input logic [12:0] a, input logic [63:0] d);
		cmd(`SDM_CMD_WR, ba, a, 4);
		for (int i = 0; i < 8; i++)
		begin
			if (i > 0)
				at(i[0] ? 6'h09 : 6'h1d);
			dq_in = d[8*i +: 8];
		end
		at(6'h1d);
		dq_in = ~d[63:56];
	endtask
	// Enable goes low together with reset, well ahead of release.
	task hold_reset(input int n);
		mem_reset_n = 1'b0;
		cke = 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
		mem_reset_n = 1'b1;
	endtask
	task wake;
		repeat (WAIT_CYC) @(posedge clk_sys);
		cmd(3'h7, 3'h0, 13'h0000, 0);
		cke = 1'b1;
		repeat (5) at(6'h1d);
	endtask
endmodule // sdm_ctl
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the DRAM command and mode block.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_init_mode_regs.vh"
module testbench;
	// =====
	// Wiring
	localparam logic [63:0] DATA = 64'h8877665544332211;
	logic clk_sys;
	logic rst_n;
	int fail_count;
	int cmp_count;
	int rl;
	wire link_ck, mem_reset_n, cke, cs_n, ras_n, cas_n, we_n, termination_control;
	wire [2:0] bank_select;
	wire [12:0] addr;
	wire [7:0] dq_in, dq_out, bank_open;
	wire dq_oe, termination_on, internal_init_busy, init_done;
	wire [4:0] read_latency_total, auto_precharge_write_delay;
	// A short internal wait keeps the run brief; the partner waits twice as long.
	sdm_init_mode_dev #(.INIT_WAIT_CYC(20)) sdm_init_mode_dev_i (
		.clk_sys, .rst_n, .link_ck, .mem_reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
		.bank_select, .addr, .termination_control, .dq_in, .dq_out, .dq_oe,
		.termination_on, .internal_init_busy, .init_done, .bank_open,
		.read_latency_total, .auto_precharge_write_delay
	);
	sdm_ctl #(.WAIT_CYC(40)) sdm_ctl_i (
		.clk_sys, .link_ck, .mem_reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
		.bank_select, .addr, .termination_control, .dq_in
	);
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmd(input logic [2:0] code, input logic [2:0] ba, input logic [12:0] a, input int gap);
		sdm_ctl_i.cmd(code, ba, a, gap);
	endtask
	task mode(input logic [2:0] ba, input logic [12:0] op);
		cmd(`SDM_CMD_MODE, ba, op, 6);
	endtask
	// Beats are sampled in mid-phase, clear of the output pipe.
	task rd(input logic [2:0] ba, input logic [12:0] a, input int n, input int b0);
		cmd(`SDM_CMD_RD, ba, a, 0);
		repeat (rl) sdm_ctl_i.at(6'h09);
		for (int i = 0; i < n; i++)
		begin
			if (i > 0)
				sdm_ctl_i.at(i[0] ? 6'h1d : 6'h09);
			cmp(dq_oe, 1'b1);
			cmp(dq_out, DATA[8*(b0+i) +: 8]);
		end
		sdm_ctl_i.at(6'h09);
		cmp(dq_oe, 1'b0);
	endtask
	task t_init(input int n);
		sdm_ctl_i.hold_reset(n);
		repeat (4) @(posedge clk_sys);
		#1;
		cmp(internal_init_busy, 1'b1);
		cmp(termination_on, 1'b0);
		sdm_ctl_i.termination_control = 1'b0;
		sdm_ctl_i.wake();
		cmp(internal_init_busy, 1'b0);
		cmp(bank_open, 8'h00);
		mode(`SDM_BA_MR2, 13'h0000);
		mode(`SDM_BA_MR3, 13'h0000);
		mode(`SDM_BA_MR1, 13'h0004);
		mode(`SDM_BA_MR0, 13'h0351);
		cmd(`SDM_CMD_CAL, 3'h0, 13'h0400, 2);
		cmp(init_done, 1'b0);
		for (int i = 0; i < 30000 && init_done !== 1'b1; i++)
			@(posedge clk_sys);
		#1;
		cmp(init_done, 1'b1);
		cmp(read_latency_total, 5'h09);
		cmp(auto_precharge_write_delay, 5'h10);
		rl = 9;
	endtask
	task t_rw;
		cmd(`SDM_CMD_RD, 3'h0, 13'h0000, 12);
		cmp(dq_oe, 1'b0);
		cmd(`SDM_CMD_ACT, 3'h5, 13'h1a03, 4);
		cmp(bank_open, 8'h20);
		cmd(`SDM_CMD_ACT, 3'h2, 13'h0001, 4);
		cmp(bank_open, 8'h24);
		sdm_ctl_i.wr(3'h5, 13'h1000, DATA);
		rd(3'h5, 13'h1000, 8, 0);
		rd(3'h5, 13'h0004, 4, 4);
		rd(3'h5, 13'h1400, 8, 0);
		repeat (20) sdm_ctl_i.at(6'h1d);
		cmp(bank_open, 8'h04);
	endtask
	// Rewrite register zero while idle; the stored word must survive.
	task t_mode;
		cmd(`SDM_CMD_PRE, 3'h0, 13'h0400, 12);
		mode(`SDM_BA_MR0, 13'h0261);
		cmp(read_latency_total, 5'h0a);
		rl = 10;
		cmd(`SDM_CMD_ACT, 3'h5, 13'h1a03, 4);
		rd(3'h5, 13'h1000, 8, 0);
	endtask
	// Termination follows its pin in service, then is off again across a warm reset.
	task t_warm;
		sdm_ctl_i.termination_control = 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		cmp(termination_on, 1'b1);
		t_init(25);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Main sequence.
	initial
	begin
		fail_count = 0;
		cmp_count = 0;
		rl = 9;
		rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		t_init(50);
		t_rw;
		t_mode;
		t_warm;
		summarize;
	end
	// Watchdog, well beyond the two long initialisation waits.
	initial
	begin
		#300000;
		fail_count++;
		summarize;
	end
endmodule // testbench
`default_nettype wire
